// ==== dacp_top.sv ====
`timescale 1ns/1ps
`include "dacp_params.svh"

module dacp_top #(
	parameter logic [15:0] DLY_LONG_CYC = `DACP_DLY_LONG_CYC
) (
	input  wire logic                   clk_sys_i,
	input  wire logic                   rstn_i,
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [3:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	input  wire logic                   swing_above_i,
	input  wire logic                   swing_below_i,
	input  wire logic                   edge_above_i,
	input  wire logic                   edge_below_i,
	input  wire logic                   range_above_i,
	input  wire logic                   range_below_i,
	input  wire logic                   calibration_delay_select_above_i,
	input  wire logic                   calibration_delay_select_below_i,
	input  wire logic                   output_clock_reset_i,
	input  wire logic                   full_power_down_i,
	input  wire logic                   second_channel_power_down_i,
	input  wire logic                   cal_request_i,
	input  wire logic [7:0]             conv_i_data_i,
	input  wire logic [7:0]             conv_i_alt_data_i,
	input  wire logic [7:0]             conv_q_data_i,
	output logic      [7:0]             dat_i_o,
	output logic      [7:0]             dat_i_dly_o,
	output logic      [7:0]             dat_q_o,
	output logic      [7:0]             dat_q_dly_o,
	output logic                        output_data_clock_o,
	output logic                        output_swing_full_o,
	output logic                        input_range_high_o,
	output logic                        extended_control_o,
	output logic                        dual_edge_mode_o,
	output logic                        calibration_in_progress_o
);
	import dacp_pkg::*;

	typedef struct packed {
		logic [`DACP_NSYNC-1:0] s1;
		logic [`DACP_NSYNC-1:0] s2;
		dacp_lvl_t              sw;
		dacp_lvl_t              eg;
		dacp_lvl_t              rg;
		dacp_lvl_t              dl;
		logic                   rst;
		logic                   pd;
		logic                   second_channel_power_down;
		logic                   cal;
		logic                   sclk_prev;
		dacp_state_t            st;
		logic [15:0]            cnt;
		logic [7:0]             low_cnt;
		logic [7:0]             high_cnt;
		logic                   low_ok;
		logic                   ph;
		logic                   output_data_clock;
		logic [7:0]             i_hold;
		logic [7:0]             q_hold;
		logic [7:0]             di;
		logic [7:0]             did;
		logic [7:0]             dq;
		logic [7:0]             dqd;
		logic [31:0]            sh;
		logic [5:0]             sh_cnt;
		logic [31:0]            ser_word;
		logic [5:0]             ser_bits;
		logic [3:0]             ctrl;
		logic                   ack;
		logic [31:0]            rdat;
	} dacp_s_t;

	dacp_s_t s_reg;
	dacp_s_t s_next;

	////////////////////////////////////////////////////////////////////////////

	function automatic dacp_lvl_t lvl_dec(input logic above, input logic below);
		if (above) begin
			lvl_dec = LVL_HI;
		end else if (below) begin
			lvl_dec = LVL_LO;
		end else begin
			lvl_dec = LVL_MID;
		end
	endfunction

	// Core delivers two's complement; flipping the sign bit gives offset binary
	function automatic logic [7:0] to_ob(input logic [7:0] d);
		to_ob = {~d[7], d[6:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////////

	logic        ext;
	logic        des;
	logic        ddr;
	logic        edge_rise;
	logic        sclk_now;
	logic        scs_n;
	logic        live;
	logic [7:0]  q_src;
	logic [15:0] dly_target;
	logic        cal_fire;
	logic        wr;

	always_comb begin
		ext        = (s_reg.rg == LVL_MID);
		des        = !ext && (s_reg.dl == LVL_MID);
		ddr        = ext ? s_reg.ctrl[`DACP_CTRL_DDR] : (s_reg.eg == LVL_MID);
		edge_rise  = ext ? s_reg.ctrl[`DACP_CTRL_EDGE_RISE] : (s_reg.eg == LVL_HI);
		sclk_now   = (s_reg.sw == LVL_HI);
		scs_n      = (s_reg.dl != LVL_LO);
		live       = (s_reg.st == ST_RUN) && !s_reg.pd;
		// Dual-edge: Q bus carries the I input taken on the other clock phase
		q_src      = des ? conv_i_alt_data_i : conv_q_data_i;
		// Long wait only when the range pin is driven and delay pin high
		dly_target = (!ext && s_reg.dl == LVL_HI) ? DLY_LONG_CYC : `DACP_DLY_SHORT_CYC;
		cal_fire   = s_reg.cal && s_reg.low_ok && (s_reg.high_cnt == `DACP_CAL_REQ_CYC - 8'd1);
		// Write lands on the edge where the master sees ack
		wr         = wb_cyc_i && wb_stb_i && wb_we_i && s_reg.ack;
	end

	always_comb begin
		s_next = s_reg;

		// Pins cross into the sample clock domain
		s_next.s1 = {cal_request_i, second_channel_power_down_i, full_power_down_i,
			output_clock_reset_i, calibration_delay_select_below_i, calibration_delay_select_above_i, range_below_i,
			range_above_i, edge_below_i, edge_above_i, swing_below_i, swing_above_i};
		s_next.s2 = s_reg.s1;
		s_next.sw  = lvl_dec(s_reg.s2[`DACP_S_SW_HI], s_reg.s2[`DACP_S_SW_LO]);
		s_next.eg  = lvl_dec(s_reg.s2[`DACP_S_EG_HI], s_reg.s2[`DACP_S_EG_LO]);
		s_next.rg  = lvl_dec(s_reg.s2[`DACP_S_RG_HI], s_reg.s2[`DACP_S_RG_LO]);
		s_next.dl  = lvl_dec(s_reg.s2[`DACP_S_DL_HI], s_reg.s2[`DACP_S_DL_LO]);
		s_next.rst = s_reg.s2[`DACP_S_RST];
		s_next.pd  = s_reg.s2[`DACP_S_PD];
		s_next.second_channel_power_down = s_reg.s2[`DACP_S_PDQ];
		s_next.cal = s_reg.s2[`DACP_S_CAL];
		s_next.sclk_prev = sclk_now;

		// Calibration request: the low count saturates, a late high phase still qualifies
		if (!s_reg.cal) begin
			s_next.high_cnt = 8'h00;
			if (s_reg.low_cnt != `DACP_CAL_REQ_CYC) begin
				s_next.low_cnt = s_reg.low_cnt + 8'd1;
			end
			// A short high glitch restarts the low phase, so a stale low phase never qualifies
			s_next.low_ok = (s_reg.low_cnt >= `DACP_CAL_REQ_CYC - 8'd1);
		end else begin
			s_next.low_cnt = 8'h00;
			if (cal_fire) begin
				s_next.low_ok   = 1'b0;
				s_next.high_cnt = 8'h00;
			end else if (s_reg.low_ok) begin
				s_next.high_cnt = s_reg.high_cnt + 8'd1;
			end
		end

		unique case (s_reg.st)
			ST_WAIT: begin
				s_next.cnt = s_reg.cnt + 16'd1;
				if (s_reg.cnt >= dly_target - 16'd1) begin
					s_next.st  = ST_CAL;
					s_next.cnt = 16'h0000;
				end
			end
			ST_CAL: begin
				s_next.cnt = s_reg.cnt + 16'd1;
				if (s_reg.cnt == `DACP_CAL_RUN_CYC - 16'd1) begin
					s_next.st  = ST_RUN;
					s_next.cnt = 16'h0000;
				end
			end
			ST_RUN: begin
				if (cal_fire) begin
					s_next.st  = ST_CAL;
					s_next.cnt = 16'h0000;
				end
			end
			ST_PD: begin
				// Leaving power-down recalibrates after the power-up wait
				if (!s_reg.pd) begin
					s_next.st  = ST_WAIT;
					s_next.cnt = 16'h0000;
				end
			end
		endcase
		if (s_reg.pd) begin
			s_next.st  = ST_PD;
			s_next.cnt = 16'h0000;
		end

		// Demux: first sample waits in the hold, second pairs with it
		if (s_reg.rst || !live) begin
			s_next.ph   = 1'b0;
			s_next.output_data_clock = 1'b0;
			s_next.di   = 8'h00;
			s_next.did  = 8'h00;
			s_next.dq   = 8'h00;
			s_next.dqd  = 8'h00;
		end else begin
			s_next.ph = ~s_reg.ph;
			// Samples arrive already taken on the falling edge of the clock's positive leg
			if (!s_reg.ph) begin
				s_next.i_hold = conv_i_data_i;
				s_next.q_hold = q_src;
			end else begin
				s_next.di  = to_ob(conv_i_data_i);
				s_next.did = to_ob(s_reg.i_hold);
				s_next.dq  = s_reg.second_channel_power_down ? 8'h00 : to_ob(q_src);
				s_next.dqd = s_reg.second_channel_power_down ? 8'h00 : to_ob(s_reg.q_hold);
			end
			if (ddr) begin
				s_next.output_data_clock = s_reg.ph ? ~s_reg.output_data_clock : s_reg.output_data_clock;
			end else begin
				s_next.output_data_clock = edge_rise ? s_reg.ph : ~s_reg.ph;
			end
		end

		// Serial port, only while the range pin floats
		if (ext && !scs_n) begin
			if (sclk_now && !s_reg.sclk_prev) begin
				s_next.sh = {s_reg.sh[30:0], (s_reg.eg == LVL_HI)};
				if (s_reg.sh_cnt != 6'h20) begin
					s_next.sh_cnt = s_reg.sh_cnt + 6'd1;
				end
			end
		end else begin
			if (s_reg.sh_cnt != 6'h00) begin
				s_next.ser_word = s_reg.sh;
				s_next.ser_bits = s_reg.sh_cnt;
			end
			s_next.sh_cnt = 6'h00;
		end

		// Wishbone slave: answer one cycle after the strobe
		s_next.ack = wb_cyc_i && wb_stb_i && !s_reg.ack;
		if (wr && wb_adr_i == `DACP_ADR_CTRL && wb_sel_i[0]) begin
			s_next.ctrl = wb_dat_i[3:0];
		end
		unique case (wb_adr_i)
			`DACP_ADR_CTRL:   s_next.rdat = {28'h0000000, s_reg.ctrl};
			`DACP_ADR_STATUS: s_next.rdat = {20'h00000, s_reg.st, ext, des, ddr, edge_rise,
				output_swing_full_o, input_range_high_o, s_reg.second_channel_power_down, s_reg.pd};
			`DACP_ADR_SERIAL: s_next.rdat = s_reg.ser_word;
			`DACP_ADR_SERCNT: s_next.rdat = {26'h0000000, s_reg.ser_bits};
			default:          s_next.rdat = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_reg      <= '0;
			s_reg.sw   <= LVL_HI;
			s_reg.eg   <= LVL_HI;
			s_reg.rg   <= LVL_LO;
			s_reg.dl   <= LVL_LO;
			s_reg.st   <= ST_WAIT;
			s_reg.ctrl <= `DACP_CTRL_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////

	assign wb_ack_o                  = s_reg.ack;
	assign wb_dat_o                  = s_reg.rdat;
	assign dat_i_o                   = s_reg.di;
	assign dat_i_dly_o               = s_reg.did;
	assign dat_q_o                   = s_reg.dq;
	assign dat_q_dly_o               = s_reg.dqd;
	assign output_data_clock_o       = s_reg.output_data_clock;
	// Serial clock toggles this pin in extended mode, so amplitude stays full
	assign output_swing_full_o       = ext || (s_reg.sw == LVL_HI);
	assign input_range_high_o        = ext ? s_reg.ctrl[`DACP_CTRL_RANGE_HI] : (s_reg.rg == LVL_HI);
	assign extended_control_o        = ext;
	assign dual_edge_mode_o          = des;
	assign calibration_in_progress_o = (s_reg.st == ST_CAL);

	////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);

	sequence cal_armed;
		s_reg.low_ok && s_reg.cal && s_reg.high_cnt == 8'd79 && s_reg.st == ST_RUN && !s_reg.pd;
	endsequence
	sequence cal_runs;
		calibration_in_progress_o [*8];
	endsequence

	AST_CAL_START: assert property (cal_armed |=> cal_runs)
		else $error("calibration did not start after request");
	AST_CAL_HOLD: assert property ($rose(calibration_in_progress_o) |-> cal_runs)
		else $error("calibration busy dropped early");
	AST_PD_ALL: assert property (s_reg.pd |=> s_reg.st == ST_PD ##1 dat_i_o == 8'h00 && dat_q_o == 8'h00)
		else $error("power-down did not stop the device");
	AST_PDQ_ONLY: assert property (live && s_reg.second_channel_power_down && s_reg.ph && !s_reg.rst |=> dat_q_o == 8'h00
		&& dat_i_o == to_ob($past(conv_i_data_i)))
		else $error("second channel power-down wrong");
	AST_OUTPUT_CLOCK_RESET: assert property (s_reg.rst |=> !output_data_clock_o && !s_reg.ph)
		else $error("output clock not reset");
	AST_DDR_TOGGLE: assert property (live && ddr && s_reg.ph && !s_reg.rst |=>
		output_data_clock_o != $past(output_data_clock_o))
		else $error("double data rate clock did not toggle");
	AST_ORDER: assert property (live && s_reg.ph && !s_reg.rst |=>
		dat_i_dly_o == to_ob($past(s_reg.i_hold)) && dat_i_o == to_ob($past(conv_i_data_i)))
		else $error("demux sample order wrong");
	AST_SER_SHIFT: assert property (ext && !scs_n && sclk_now && !s_reg.sclk_prev |=>
		s_reg.sh[0] == $past(s_reg.eg == LVL_HI))
		else $error("serial bit not shifted in");
	AST_RANGE: assert property (s_reg.s2[`DACP_S_RG_LO] && !s_reg.s2[`DACP_S_RG_HI] |=> !input_range_high_o)
		else $error("range select wrong");

endmodule

// ==== dacp_params.svh ====
`ifndef DACP_PARAMS_SVH
`define DACP_PARAMS_SVH

// Wishbone register offsets (byte addresses)
`define DACP_ADR_CTRL       4'h0
`define DACP_ADR_STATUS     4'h4
`define DACP_ADR_SERIAL     4'h8
`define DACP_ADR_SERCNT     4'hC

// Control register fields, used only in extended control mode
`define DACP_CTRL_EDGE_RISE 0
`define DACP_CTRL_DDR       1
`define DACP_CTRL_RANGE_HI  2
`define DACP_CTRL_RESET     4'h1

// Synchroniser bit positions
`define DACP_S_SW_HI        0
`define DACP_S_SW_LO        1
`define DACP_S_EG_HI        2
`define DACP_S_EG_LO        3
`define DACP_S_RG_HI        4
`define DACP_S_RG_LO        5
`define DACP_S_DL_HI        6
`define DACP_S_DL_LO        7
`define DACP_S_RST          8
`define DACP_S_PD           9
`define DACP_S_PDQ          10
`define DACP_S_CAL          11
`define DACP_NSYNC          12

// Timing counts in sample clock cycles
`define DACP_CAL_REQ_CYC    8'd80
`define DACP_CAL_RUN_CYC    16'd1024
`define DACP_DLY_SHORT_CYC  16'd256
`define DACP_DLY_LONG_CYC   16'd8192

`endif

// ==== dacp_pkg.sv ====
package dacp_pkg;

	typedef enum logic [1:0] {
		LVL_LO  = 2'h0,
		LVL_MID = 2'h1,
		LVL_HI  = 2'h2
	} dacp_lvl_t;

	typedef enum logic [3:0] {
		ST_WAIT = 4'h1,
		ST_CAL  = 4'h2,
		ST_RUN  = 4'h4,
		ST_PD   = 4'h8
	} dacp_state_t;

endpackage

// ==== dacp_host_model.sv ====
`timescale 1ns/1ps
module dacp_host_model
	import dacp_pkg::*;
(
	input  wire logic       clk_sys_i,
	output logic            sw_above_o,
	output logic            sw_below_o,
	output logic            eg_above_o,
	output logic            eg_below_o,
	output logic            rg_above_o,
	output logic            rg_below_o,
	output logic            dl_above_o,
	output logic            dl_below_o,
	output logic [7:0]      i_o,
	output logic [7:0]      alt_o,
	output logic [7:0]      q_o
);
	dacp_lvl_t  sw   = LVL_HI;
	dacp_lvl_t  eg   = LVL_LO;
	dacp_lvl_t  rg   = LVL_LO;
	dacp_lvl_t  dl   = LVL_HI;
	logic [7:0] smp  = 8'h05;
	logic       ramp = 1'b0;
	////////////////////////////////////////////////////////////
	// Floating pin shows neither comparator active
	assign sw_above_o = (sw == LVL_HI);
	assign sw_below_o = (sw == LVL_LO);
	assign eg_above_o = (eg == LVL_HI);
	assign eg_below_o = (eg == LVL_LO);
	assign rg_above_o = (rg == LVL_HI);
	assign rg_below_o = (rg == LVL_LO);
	assign dl_above_o = (dl == LVL_HI);
	assign dl_below_o = (dl == LVL_LO);
	assign i_o        = smp;
	assign alt_o      = smp ^ 8'h40;
	assign q_o        = 8'h00 - smp;
	// Dropping the ramp returns the samples to their rest value
	always @(posedge clk_sys_i) begin
		if (ramp)
			smp <= smp + 8'h01;
		else
			smp <= 8'h05;
	end
	////////////////////////////////////////////////////////////
	// Serial clock idles low outside frames; 80 ns per bit
	task automatic send(input logic [31:0] w, input int n);
		@(posedge clk_sys_i);
		dl <= LVL_LO;
		repeat (4) @(posedge clk_sys_i);
		for (int b = n - 1; b >= 0; b--) begin
			eg <= w[b] ? LVL_HI : LVL_LO;
			sw <= LVL_LO;
			repeat (4) @(posedge clk_sys_i);
			sw <= LVL_HI;
			repeat (4) @(posedge clk_sys_i);
		end
		sw <= LVL_LO;
		repeat (4) @(posedge clk_sys_i);
		dl <= LVL_HI;
		repeat (8) @(posedge clk_sys_i);
	endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
`include "dacp_params.svh"
module testbench;
	import dacp_pkg::*;
	logic        clk_sys_i = 1'b0;
	logic        rstn_i    = 1'b0;
	logic        wb_cyc_i  = 1'b0;
	logic        wb_stb_i  = 1'b0;
	logic        wb_we_i   = 1'b0;
	logic [3:0]  wb_adr_i  = 4'h0;
	logic [3:0]  wb_sel_i  = 4'hF;
	logic [31:0] wb_dat_i  = 32'h0;
	logic        ocr       = 1'b0;
	logic        pd        = 1'b0;
	logic        second_channel_power_down       = 1'b0;
	logic        cal       = 1'b1;
	logic [31:0] wb_dat_o, rd;
	logic        wb_ack_o, sa, sb, ea, eb, ra, rb, da, db;
	logic [7:0]  ci, ca, cq, di, did, dq, dqd, p8;
	logic        output_data_clock, swf, rgh, ext, des, busy;
	int          error_cnt = 0;
	int          checks    = 0;
	int          n;
	always #5 clk_sys_i = ~clk_sys_i;
	dacp_host_model host (.clk_sys_i(clk_sys_i), .sw_above_o(sa), .sw_below_o(sb), .eg_above_o(ea),
		.eg_below_o(eb), .rg_above_o(ra), .rg_below_o(rb), .dl_above_o(da), .dl_below_o(db),
		.i_o(ci), .alt_o(ca), .q_o(cq));
	// Short power-up wait keeps the run brief
	dacp_top #(.DLY_LONG_CYC(16'd300)) dacp_top_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.swing_above_i(sa), .swing_below_i(sb), .edge_above_i(ea), .edge_below_i(eb),
		.range_above_i(ra), .range_below_i(rb), .calibration_delay_select_above_i(da), .calibration_delay_select_below_i(db),
		.output_clock_reset_i(ocr), .full_power_down_i(pd), .second_channel_power_down_i(second_channel_power_down),
		.cal_request_i(cal), .conv_i_data_i(ci), .conv_i_alt_data_i(ca), .conv_q_data_i(cq),
		.dat_i_o(di), .dat_i_dly_o(did), .dat_q_o(dq), .dat_q_dly_o(dqd), .output_data_clock_o(output_data_clock),
		.output_swing_full_o(swf), .input_range_high_o(rgh), .extended_control_o(ext),
		.dual_edge_mode_o(des), .calibration_in_progress_o(busy));
	////////////////////////////////////////////////////////////
	task automatic conclude;
		if (error_cnt == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
		@(posedge clk_sys_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, s};
		do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
		@(posedge clk_sys_i);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk_sys_i);
	endtask
	// Counts output clock toggles over 16 cycles
	task automatic tog(output int t);
		logic p;
		t = 0;
		p = output_data_clock;
		repeat (16) begin
			@(negedge clk_sys_i);
			t += int'(output_data_clock !== p);
			p = output_data_clock;
		end
	endtask
	task automatic busy_wait(input int lim);
		n = 0;
		while (busy !== 1'b1 && n < lim) begin
			@(negedge clk_sys_i);
			n++;
		end
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		busy_wait(3000);
		chk("power_up_wait", (n > 290 && n < 310), 1);
		n = 0;
		while (busy === 1'b1) begin
			@(negedge clk_sys_i);
			n++;
		end
		chk("cal_len", n, `DACP_CAL_RUN_CYC);
		cyc(8);
		chk("swing_full", swf, 1);
		chk("range_high", rgh, 0);
		chk("ext", ext, 0);
		chk("dat_i", di, 8'h85);
		chk("dat_i_dly", did, 8'h85);
		chk("dat_q", dq, 8'h7B);
		tog(n);
		chk("sdr_toggles", n, 16);
		@(posedge clk_sys_i);
		host.ramp <= 1'b1;
		cyc(8);
		chk("i_order", 8'(di - did), 8'h01);
		chk("q_order", 8'(dqd - dq), 8'h01);
		p8 = di;
		cyc(1);
		if (di === p8)
			cyc(1);
		chk("edge_fall", output_data_clock, 0);
		@(posedge clk_sys_i);
		host.eg <= LVL_HI;
		cyc(8);
		p8 = di;
		cyc(1);
		if (di === p8)
			cyc(1);
		chk("edge_rise", output_data_clock, 1);
		@(posedge clk_sys_i);
		host.ramp <= 1'b0;
		host.eg <= LVL_MID;
		cyc(10);
		tog(n);
		chk("ddr_toggles", n, 8);
		wb(1'b0, `DACP_ADR_STATUS, 32'h0);
		chk("status_ddr", rd[5], 1);
		@(posedge clk_sys_i);
		host.eg <= LVL_LO;
		ocr <= 1'b1;
		cyc(6);
		chk("output_clock_reset", output_data_clock, 0);
		chk("dat_rst", di, 8'h00);
		@(posedge clk_sys_i);
		ocr <= 1'b0;
		host.sw <= LVL_LO;
		host.rg <= LVL_HI;
		host.dl <= LVL_MID;
		cyc(10);
		chk("dat_resync", di, 8'h85);
		chk("swing_low", swf, 0);
		chk("range_hi", rgh, 1);
		chk("des", des, 1);
		chk("des_q", dq, 8'hC5);
		@(posedge clk_sys_i);
		host.dl <= LVL_HI;
		second_channel_power_down <= 1'b1;
		cyc(8);
		chk("pdq_q", dq, 8'h00);
		chk("pdq_i", di, 8'h85);
		@(posedge clk_sys_i);
		second_channel_power_down <= 1'b0;
		cal <= 1'b0;
		repeat (40) @(posedge clk_sys_i);
		cal <= 1'b1;
		cyc(100);
		chk("cal_short", busy, 0);
		@(posedge clk_sys_i);
		cal <= 1'b0;
		repeat (90) @(posedge clk_sys_i);
		cal <= 1'b1;
		busy_wait(200);
		chk("cal_start", busy, 1);
		while (busy === 1'b1) @(negedge clk_sys_i);
		wb(1'b1, `DACP_ADR_CTRL, 32'h6);
		wb(1'b1, `DACP_ADR_CTRL, 32'h1, 4'hE);
		wb(1'b0, `DACP_ADR_CTRL, 32'h0);
		chk("ctrl", rd, 32'h6);
		wb(1'b1, 4'h2, 32'hF);
		wb(1'b0, 4'h2, 32'h0);
		chk("unmapped", rd, 32'h0);
		@(posedge clk_sys_i);
		host.rg <= LVL_MID;
		cyc(8);
		chk("ext_on", ext, 1);
		chk("ext_range", rgh, 1);
		host.send(32'hA5C, 12);
		wb(1'b0, `DACP_ADR_SERIAL, 32'h0);
		chk("serial", rd, 32'hA5C);
		wb(1'b0, `DACP_ADR_SERCNT, 32'h0);
		chk("sercnt", rd, 32'd12);
		@(posedge clk_sys_i);
		host.rg <= LVL_LO;
		pd <= 1'b1;
		cyc(8);
		chk("pd_dat", di, 8'h00);
		chk("pd_output_data_clock", output_data_clock, 0);
		wb(1'b0, `DACP_ADR_STATUS, 32'h0);
		chk("pd_state", rd[11:8], 4'h8);
		conclude();
	end
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		error_cnt++;
		conclude();
	end
endmodule
